// ### hdl/dwp_buf.sv
// small valid/ready buffer for write beats
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
module dwp_buf #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 2
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [CW-1:0]    cnt_q, cnt_d;
  logic             push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_ready_o  = (cnt_q != CW'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_ptr_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    wr_ptr_d = push ? bump(wr_ptr_q) : wr_ptr_q;
    rd_ptr_d = pop ? bump(rd_ptr_q) : rd_ptr_q;
    cnt_d    = CW'(cnt_q + CW'(push) - CW'(pop));
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q    <= cnt_d;
    end
  end

  // storage carries no reset; only the count says what is valid
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end
endmodule

// ### hdl/dwp_write_phy.sv
// ddr write-side phy: phase enables from the memory clock, paired output registers,
// two-register output enables with strobe preamble, command pins, read capture.
// assumes link_clk_i is the memory system clock from the pll, slower than core_clk_i.
// Summary of operation
// - output enables of each pin use two ddr registers; strobe needs both low, data only the second.
// - second enable register keeps strobe high-impedance half a cycle longer.
// - enable registers hold active-low values; an inverter feeds the first.
// - system, write, capture phases derive from the clock; core clock runs logic.
// - strobe, command and address pins change on system clock phase.
// - write data pins change on a write phase lagging system by ninety degrees.
// - capture phase is stepped and tracked to balance read margins.
// - low and high halves load together; low on falling, high on rising.
// - mask pins follow write phase; low writes a byte, high masks it.
// - reads are captured by the capture phase; read strobe is never used.
`timescale 1ns/1ps
`include "dwp_defs.svh"
module dwp_write_phy import dwp_pkg::*; #(
  parameter int BUF_DEPTH = `DWP_BUF_DEPTH
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   link_clk_i,
  input  wire logic                   wr_valid_i,
  output logic                        wr_ready_o,
  input  wire dwp_beat_type           wr_beat_i,
  input  wire logic                   cmd_valid_i,
  output logic                        cmd_ready_o,
  input  wire dwp_cmd_type            cmd_i,
  input  wire logic                   rd_en_i,
  output logic                        rd_valid_o,
  output dwp_rd_word_type             rd_word_o,
  input  wire logic                   cap_inc_i,
  input  wire logic                   cap_dec_i,
  output logic [`DWP_PH_W-1:0]        cap_phase_o,
  output logic                        locked_o,
  output dwp_cmd_type                 mem_cmd_o,
  input  wire logic [`DWP_DQ_W-1:0]   dq_i,
  output logic [`DWP_DQ_W-1:0]        dq_o,
  output logic                        dq_oe_o,
  output logic [`DWP_DM_W-1:0]        dm_o,
  output logic                        dqs_o,
  output logic                        dqs_oe_o
);
  localparam int PH_W = `DWP_PH_W;
  localparam logic [PH_W-1:0] PH_MAX = '1;

  logic                  lk_s1_q, lk_s2_q, lk_s3_q;
  logic [`DWP_DQ_W-1:0]  dq_s1_q, dq_s2_q;
  logic [PH_W-1:0]       ph_q, ph_d, per_q, per_d, cap_q, cap_d;
  logic [1:0]            rises_q, rises_d;
  logic                  locked_q, locked_d;
  logic                  lk_rise, lk_fall, sys_rise, sys_fall, wr_rise, wr_fall, cap_rise, cap_fall;
  logic [PH_W-1:0]       half, lag;
  dwp_wr_state_type      st_q, st_d;
  dwp_half_type          fe_out_q, fe_out_d, re_out_q, re_out_d;
  logic [`DWP_DQ_W-1:0]  dq_q, dq_d;
  logic [`DWP_DM_W-1:0]  dm_q, dm_d;
  logic                  dq_oe_a_n_q, dq_oe_a_n_d, dq_oe_b_n_q, dq_oe_b_n_d;
  logic                  dqs_oe_a_n_q, dqs_oe_a_n_d, dqs_oe_b_n_q, dqs_oe_b_n_d;
  logic                  dqs_q, dqs_d, loaded_q, loaded_d;
  dwp_cmd_type           cmd_q, cmd_d;
  logic [`DWP_DQ_W-1:0]  cap_a_q, cap_a_d;
  dwp_rd_word_type       rd_q, rd_d;
  logic                  rd_v_q, rd_v_d;
  logic                  buf_valid, load;
  dwp_beat_type          buf_beat;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // wraps a phase in 1..per
  function automatic logic [PH_W-1:0] wrap_ph(input logic [PH_W:0] x, input logic [PH_W-1:0] per);
    return (x > {1'b0, per}) ? PH_W'(x - {1'b0, per}) : x[PH_W-1:0];
  endfunction

  // write beats wait here while the burst engine is between phases
  dwp_buf #(
    .WIDTH ($bits(dwp_beat_type)),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (wr_valid_i),
    .in_ready_o  (wr_ready_o),
    .in_data_i   (wr_beat_i),
    .out_valid_o (buf_valid),
    .out_ready_i (load),
    .out_data_o  (buf_beat)
  );

  // phase generator: the sampled clock edges fix the system phase, others are offsets
  assign lk_rise  = lk_s2_q && !lk_s3_q;
  assign lk_fall  = !lk_s2_q && lk_s3_q;
  assign half     = per_q >> 1;
  assign lag      = PH_W'((32'(per_q) * `DWP_WR_LAG_DEG) / 360);
  assign sys_rise = locked_q && lk_rise;
  assign sys_fall = locked_q && lk_fall;
  assign wr_rise  = locked_q && (ph_q == lag);
  assign wr_fall  = locked_q && (ph_q == wrap_ph({1'b0, lag} + {1'b0, half}, per_q));
  assign cap_rise = locked_q && (ph_q == cap_q);
  assign cap_fall = locked_q && (ph_q == wrap_ph({1'b0, cap_q} + {1'b0, half}, per_q));

  always_comb begin
    ph_d     = lk_rise ? PH_W'(1) : ((ph_q == PH_MAX) ? ph_q : PH_W'(ph_q + 1'b1));
    per_d    = lk_rise ? ph_q : per_q;
    rises_d  = (lk_rise && rises_q != 2'h2) ? 2'(rises_q + 1'b1) : rises_q;
    locked_d = locked_q;
    if (ph_q == PH_MAX) begin
      // a stopped memory clock drops lock and stalls every phase
      rises_d  = '0;
      locked_d = 1'b0;
    end else if (lk_rise && rises_q != 2'h0) begin
      locked_d = (ph_q >= `DWP_PER_MIN);
    end
    cap_d = cap_q;
    if (cap_q > per_q) begin
      cap_d = per_q;
    end else if (cap_inc_i && !cap_dec_i) begin
      cap_d = (cap_q >= per_q) ? PH_W'(1) : PH_W'(cap_q + 1'b1);
    end else if (cap_dec_i && !cap_inc_i) begin
      cap_d = (cap_q <= PH_W'(1)) ? per_q : PH_W'(cap_q - 1'b1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      lk_s1_q  <= 1'b0;
      lk_s2_q  <= 1'b0;
      lk_s3_q  <= 1'b0;
      dq_s1_q  <= '0;
      dq_s2_q  <= '0;
      ph_q     <= '0;
      per_q    <= PH_W'(`DWP_LINK_CYC);
      rises_q  <= '0;
      locked_q <= 1'b0;
      cap_q    <= `DWP_CAP_INIT;
    end else begin
      lk_s1_q  <= link_clk_i;
      lk_s2_q  <= lk_s1_q;
      lk_s3_q  <= lk_s2_q;
      dq_s1_q  <= dq_i;
      dq_s2_q  <= dq_s1_q;
      ph_q     <= ph_d;
      per_q    <= per_d;
      rises_q  <= rises_d;
      locked_q <= locked_d;
      cap_q    <= cap_d;
    end
  end

  // write burst engine on the system phase; beats load on the write phase
  assign load = wr_rise && buf_valid && (st_q == dwp_st_pre || st_q == dwp_st_burst);

  always_comb begin
    st_d         = st_q;
    dqs_d        = dqs_q;
    dqs_oe_a_n_d = dqs_oe_a_n_q;
    dqs_oe_b_n_d = dqs_oe_b_n_q;
    loaded_d     = wr_rise ? load : loaded_q;
    if (sys_rise) begin
      unique case (st_q)
        dwp_st_idle:  st_d = buf_valid ? dwp_st_pre : dwp_st_idle;
        dwp_st_pre:   st_d = dwp_st_burst;
        dwp_st_burst: st_d = loaded_q ? dwp_st_burst : dwp_st_post;
        dwp_st_post:  st_d = dwp_st_idle;
      endcase
      dqs_d        = loaded_q && (st_q == dwp_st_pre || st_q == dwp_st_burst);
      dqs_oe_a_n_d = ~(st_d != dwp_st_idle);
    end
    if (sys_fall) begin
      dqs_d        = 1'b0;
      // the enable reaches the pin only once both registers agree
      dqs_oe_b_n_d = dqs_oe_a_n_q;
    end
  end

  // paired output registers and the data-side enable pair on the write phase
  always_comb begin
    fe_out_d    = fe_out_q;
    re_out_d    = re_out_q;
    dq_d        = dq_q;
    dm_d        = dm_q;
    dq_oe_a_n_d = dq_oe_a_n_q;
    dq_oe_b_n_d = dq_oe_b_n_q;
    if (wr_rise) begin
      fe_out_d    = load ? dwp_half_type'{dq: buf_beat.dq_lo, dm: buf_beat.dm_lo}
                         : dwp_half_type'{dq: fe_out_q.dq, dm: '1};
      re_out_d    = load ? dwp_half_type'{dq: buf_beat.dq_hi, dm: buf_beat.dm_hi}
                         : dwp_half_type'{dq: re_out_q.dq, dm: '1};
      dq_d        = re_out_q.dq;
      dm_d        = re_out_q.dm;
      dq_oe_a_n_d = ~load;
    end
    if (wr_fall) begin
      dq_d        = fe_out_q.dq;
      dm_d        = fe_out_q.dm;
      dq_oe_b_n_d = dq_oe_a_n_q;
    end
  end

  // command pins and read capture; the read strobe has no input at all
  always_comb begin
    cmd_d   = cmd_q;
    cap_a_d = cap_rise ? dq_s2_q : cap_a_q;
    rd_d    = rd_q;
    rd_v_d  = 1'b0;
    if (sys_rise) begin
      cmd_d = cmd_valid_i ? cmd_i : dwp_cmd_type'{cmd: `DWP_CMD_NOP, addr: cmd_q.addr};
    end
    if (cap_fall && rd_en_i) begin
      rd_d   = '{hi: dq_s2_q, lo: cap_a_q};
      rd_v_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_q         <= dwp_st_idle;
      dqs_q        <= 1'b0;
      dqs_oe_a_n_q <= 1'b1;
      dqs_oe_b_n_q <= 1'b1;
      loaded_q     <= 1'b0;
      fe_out_q     <= '{dq: '0, dm: '1};
      re_out_q     <= '{dq: '0, dm: '1};
      dq_q         <= '0;
      dm_q         <= '1;
      dq_oe_a_n_q  <= 1'b1;
      dq_oe_b_n_q  <= 1'b1;
      cmd_q        <= '{cmd: `DWP_CMD_NOP, addr: '0};
      cap_a_q      <= '0;
      rd_q         <= '0;
      rd_v_q       <= 1'b0;
    end else begin
      st_q         <= st_d;
      dqs_q        <= dqs_d;
      dqs_oe_a_n_q <= dqs_oe_a_n_d;
      dqs_oe_b_n_q <= dqs_oe_b_n_d;
      loaded_q     <= loaded_d;
      fe_out_q     <= fe_out_d;
      re_out_q     <= re_out_d;
      dq_q         <= dq_d;
      dm_q         <= dm_d;
      dq_oe_a_n_q  <= dq_oe_a_n_d;
      dq_oe_b_n_q  <= dq_oe_b_n_d;
      cmd_q        <= cmd_d;
      cap_a_q      <= cap_a_d;
      rd_q         <= rd_d;
      rd_v_q       <= rd_v_d;
    end
  end

  assign cmd_ready_o = sys_rise;
  assign mem_cmd_o   = cmd_q;
  assign dq_o        = dq_q;
  assign dm_o        = dm_q;
  assign dqs_o       = dqs_q;
  // strobe turns on late and off at once; data follows the second register alone
  assign dqs_oe_o    = ~(dqs_oe_a_n_q | dqs_oe_b_n_q);
  assign dq_oe_o     = ~dq_oe_b_n_q;
  assign rd_valid_o  = rd_v_q;
  assign rd_word_o   = rd_q;
  assign cap_phase_o = cap_q;
  assign locked_o    = locked_q;

  dq_oe_turn_a:     assert property ($rose(dq_oe_o) |-> $past(wr_fall) && $past(load, 5))
    else $error("data enable rose off the write falling phase");
  dqs_preamble_a:   assert property ($rose(dqs_oe_o) |-> $past(sys_fall) && !dqs_o)
    else $error("strobe driver turned on without the half-cycle extension");
  oe_active_low_a:  assert property ($fell(dqs_oe_a_n_q) |-> $past(sys_rise) && st_q != dwp_st_idle)
    else $error("strobe enable register went low outside a burst");
  sys_period_a:     assert property (sys_rise |=> !sys_rise [*3])
    else $error("system phase repeats faster than four cycles");
  cmd_on_sys_a:     assert property ($changed(mem_cmd_o) |-> $past(sys_rise))
    else $error("command pins changed off the system phase");
  wr_lag_a:         assert property (sys_rise && per_q == 5'h08 |-> ##2 wr_rise)
    else $error("write phase does not lag by a quarter period");
  cap_step_a:       assert property (cap_inc_i && !cap_dec_i && cap_q < per_q |=>
                                     cap_q == $past(cap_q) + 5'h01)
    else $error("capture phase did not step");
  ddr_order_a:      assert property (load && per_q == 5'h08 && $stable(per_q) |->
                                     ##5 (dq_o == $past(buf_beat.dq_lo, 5)) ##4 (dq_o == $past(buf_beat.dq_hi, 9)))
    else $error("low and high halves left the pins out of order");
  dm_idle_a:        assert property (!dq_oe_o |-> &dm_o)
    else $error("mask not high while data pins are idle");
  rd_capture_a:     assert property (rd_valid_o |-> $past(cap_fall) && rd_word_o.hi == $past(dq_s2_q))
    else $error("read word not taken on the capture phase");

  burst_c:   cover property (st_q == dwp_st_burst ##[1:40] st_q == dwp_st_post);
  read_c:    cover property (rd_valid_o);
  adjust_c:  cover property (cap_inc_i ##[1:40] cap_dec_i);
  cmd_c:     cover property (cmd_valid_i && cmd_ready_o);
endmodule

// ### include/dwp_defs.svh
// constants of the ddr write path: pin widths, command codes, clock figures
// assumes inclusion by bare name from the package and the design files
`ifndef DWP_DEFS_SVH
`define DWP_DEFS_SVH
`define DWP_DQ_W        8
`define DWP_DM_W        1
`define DWP_ADDR_W      13
`define DWP_CMD_W       3
`define DWP_CMD_NOP     3'h7
`define DWP_CORE_CLK_NS 40
`define DWP_LINK_CLK_NS 320
`define DWP_LINK_CYC    (`DWP_LINK_CLK_NS / `DWP_CORE_CLK_NS)
`define DWP_PH_W        5
`define DWP_PER_MIN     5'h04
`define DWP_WR_LAG_DEG  90
`define DWP_CAP_INIT    5'h04
`define DWP_BUF_DEPTH   2
`endif

// ### include/dwp_pkg.sv
// types shared by the ddr write path and its testbench
// assumes dwp_defs.svh on the include path
`include "dwp_defs.svh"
package dwp_pkg;
  typedef struct packed {
    logic [`DWP_DQ_W-1:0] dq_hi;
    logic [`DWP_DQ_W-1:0] dq_lo;
    logic [`DWP_DM_W-1:0] dm_hi;
    logic [`DWP_DM_W-1:0] dm_lo;
  } dwp_beat_type;
  typedef struct packed {
    logic [`DWP_DQ_W-1:0] dq;
    logic [`DWP_DM_W-1:0] dm;
  } dwp_half_type;
  typedef struct packed {
    logic [`DWP_CMD_W-1:0]  cmd;
    logic [`DWP_ADDR_W-1:0] addr;
  } dwp_cmd_type;
  typedef struct packed {
    logic [`DWP_DQ_W-1:0] hi;
    logic [`DWP_DQ_W-1:0] lo;
  } dwp_rd_word_type;
  typedef enum logic [1:0] {
    dwp_st_idle  = 2'b00,
    dwp_st_pre   = 2'b01,
    dwp_st_burst = 2'b10,
    dwp_st_post  = 2'b11
  } dwp_wr_state_type;
endpackage

// ### test/dwp_mem_model.sv
// far-side memory model: takes write bytes on both strobe edges and drives read bytes
// assumes the phy centres data on the strobe edges and enables both pins before the first edge
`timescale 1ns/1ps
`include "dwp_defs.svh"
module dwp_mem_model (
  input  wire logic                 core_clk_i,
  input  wire logic                 rd_drive_i,
  input  wire logic [`DWP_DQ_W-1:0] rd_byte_i,
  input  wire logic [`DWP_DQ_W-1:0] dq_pin_i,
  input  wire logic                 dq_oe_i,
  input  wire logic [`DWP_DM_W-1:0] dm_pin_i,
  input  wire logic                 dqs_pin_i,
  input  wire logic                 dqs_oe_i,
  output logic [`DWP_DQ_W-1:0]      dq_pin_o
);
  logic [`DWP_DQ_W-1:0] got[$];
  logic [`DWP_DQ_W-1:0] bus_q = 8'h5a;
  // a driven strobe edge latches the byte; a high mask makes the memory drop it
  always @(posedge dqs_pin_i or negedge dqs_pin_i) begin
    if (dqs_oe_i === 1'b1 && dq_oe_i === 1'b1 && dm_pin_i === 1'b0) begin
      got.push_back(dq_pin_i);
    end
  end
  // no pull on the data lines: once released they toggle, so a stale byte cannot pass for data
  always @(posedge core_clk_i) begin
    if (rd_drive_i) begin
      bus_q <= rd_byte_i;
    end else begin
      bus_q <= ~bus_q;
    end
  end
  assign dq_pin_o = bus_q;
endmodule

// ### test/testbench.sv
// self-checking bench for the ddr write phy: write stream, commands, capture phase, reads
// assumes dwp_mem_model on the pins and a free-running memory system clock
`timescale 1ns/1ps
`include "dwp_defs.svh"
module testbench import dwp_pkg::*; ;
  localparam int PER = `DWP_LINK_CYC;
  logic                 clk = 1'b0, rst_n = 1'b0, link_clk = 1'b0, rd_drive = 1'b0;
  logic                 wr_valid = 1'b0, cmd_valid = 1'b0, rd_en = 1'b0, cap_inc = 1'b0, cap_dec = 1'b0;
  logic                 wr_ready, cmd_ready, rd_valid, locked, dq_oe, dqs, dqs_oe, dqs_d = 1'b0, armed = 1'b1;
  dwp_beat_type         wr_beat = '0;
  dwp_cmd_type          cmd = '0;
  dwp_cmd_type          mem_cmd;
  dwp_rd_word_type      rd_word;
  logic [`DWP_DQ_W-1:0] rd_byte = 8'h00, prev_hi = 8'h00, dq_d = 8'h00, dq_in, dq_out;
  logic [`DWP_DM_W-1:0] dm;
  logic [`DWP_PH_W-1:0] cap_phase;
  logic [31:0]          seed = 32'hc312;
  logic [`DWP_DQ_W-1:0] exp_q[$];
  int                   errors = 0, checks = 0, pre_cnt = 0, dq_age = 0, cap_m = `DWP_CAP_INIT;

  dwp_write_phy #(.BUF_DEPTH(2)) i_dwp_write_phy (
    .core_clk_i(clk), .rst_n_i(rst_n), .link_clk_i(link_clk), .wr_valid_i(wr_valid),
    .wr_ready_o(wr_ready), .wr_beat_i(wr_beat), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_i(cmd), .rd_en_i(rd_en), .rd_valid_o(rd_valid), .rd_word_o(rd_word), .cap_inc_i(cap_inc),
    .cap_dec_i(cap_dec), .cap_phase_o(cap_phase), .locked_o(locked), .mem_cmd_o(mem_cmd),
    .dq_i(dq_in), .dq_o(dq_out), .dq_oe_o(dq_oe), .dm_o(dm), .dqs_o(dqs), .dqs_oe_o(dqs_oe));
  dwp_mem_model i_dwp_mem_model (
    .core_clk_i(clk), .rd_drive_i(rd_drive), .rd_byte_i(rd_byte), .dq_pin_i(dq_out), .dq_oe_i(dq_oe),
    .dm_pin_i(dm), .dqs_pin_i(dqs), .dqs_oe_i(dqs_oe), .dq_pin_o(dq_in));

  initial begin
    forever #20 clk = ~clk;
  end
  // odd start offset keeps the memory clock edges off the core clock edges
  initial begin
    #7;
    forever #160 link_clk = ~link_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic close_out();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // halves always differ from their neighbours so the launch of each byte shows on the pins
  task automatic put_beat(input logic full_chk);
    logic [31:0]  r;
    dwp_beat_type b;
    int           n;
    r = xs();
    b.dq_lo = r[7:0] | 8'h01;
    if (b.dq_lo == prev_hi) b.dq_lo = b.dq_lo ^ 8'h02;
    b.dq_hi = ~b.dq_lo;
    b.dm_lo = r[8];
    b.dm_hi = r[9];
    prev_hi = b.dq_hi;
    if (b.dm_lo == 1'b0) exp_q.push_back(b.dq_lo);
    if (b.dm_hi == 1'b0) exp_q.push_back(b.dq_hi);
    wr_valid = 1'b1;
    wr_beat = b;
    if (full_chk) begin
      repeat (3) @(negedge clk);
      cmp(wr_ready, 1'b0, "ready with full buffer");
    end
    // ready is looked at mid-cycle, so the edge that follows is the one that takes the beat
    n = 0;
    while (wr_ready !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n >= 400) cmp(n, 0, "write handshake");
    @(negedge clk);
  endtask

  task automatic put_cmd(input dwp_cmd_type c);
    int n;
    cmd_valid = 1'b1;
    cmd = c;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) cmp(n, 0, "command handshake");
    @(negedge clk);
    cmd_valid = 1'b0;
    cmp(mem_cmd, c, "command on pins");
    repeat (PER - 1) @(negedge clk);
    cmp(mem_cmd, c, "command held one period");
    @(negedge clk);
    cmp(mem_cmd.cmd, `DWP_CMD_NOP, "idle code after period");
  endtask

  // pin monitor: data launch a quarter period before each strobe edge, preamble half a period
  always @(negedge clk) begin
    if (dq_out !== dq_d) dq_age = 0;
    else dq_age++;
    if (rst_n === 1'b1 && dqs_oe === 1'b1 && dq_oe === 1'b1 && dqs !== dqs_d) begin
      cmp(dq_age, PER / 4, "data to strobe spacing");
    end
    if (dqs_oe !== 1'b1) begin
      armed = 1'b1;
      pre_cnt = 0;
    end else if (armed && dqs === 1'b0) begin
      pre_cnt++;
    end else if (armed) begin
      armed = 1'b0;
      cmp(pre_cnt, PER / 2, "strobe preamble length");
    end
    dq_d = dq_out;
    dqs_d = dqs;
  end

  initial begin
    repeat (8000) @(posedge clk);
    errors++;
    $display("MISMATCH at %0t: run did not finish", $time);
    close_out();
  end

  initial begin
    logic [31:0] r;
    dwp_cmd_type c;
    int          n;
    repeat (6) @(negedge clk);
    cmp({dq_oe, dqs_oe, dm, rd_valid, locked, wr_ready, cap_phase, mem_cmd},
        {3'b001, 3'b001, `DWP_CAP_INIT, `DWP_CMD_NOP, 13'h0000}, "reset state");
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    put_beat(1'b0);
    put_beat(1'b0);
    put_beat(1'b1);
    for (int i = 0; i < 3; i++) put_beat(1'b0);
    wr_valid = 1'b0;
    repeat (5 * PER) @(negedge clk);
    put_beat(1'b0);
    put_beat(1'b0);
    wr_valid = 1'b0;
    repeat (12 * PER) @(negedge clk);
    cmp(locked, 1'b1, "clock lock");
    cmp(i_dwp_mem_model.got.size(), exp_q.size(), "bytes written");
    foreach (exp_q[i]) begin
      if (i < i_dwp_mem_model.got.size()) cmp(i_dwp_mem_model.got[i], exp_q[i], "written byte");
    end
    for (int i = 0; i < 7; i++) begin
      r = xs();
      c = {i[2:0], r[12:0]};
      put_cmd(c);
    end
    for (int i = 0; i < 24; i++) begin
      r = xs();
      cap_inc = (i < 6) | r[0];
      cap_dec = (i >= 6) & r[1];
      if (cap_inc && !cap_dec) cap_m = (cap_m == PER) ? 1 : cap_m + 1;
      else if (cap_dec && !cap_inc) cap_m = (cap_m == 1) ? PER : cap_m - 1;
      @(negedge clk);
      cap_inc = 1'b0;
      cap_dec = 1'b0;
      cmp(cap_phase, cap_m, "capture phase step");
      @(negedge clk);
    end
    rd_drive = 1'b1;
    for (int k = 0; k < 4; k++) begin
      r = xs();
      rd_byte = r[7:0];
      repeat (3 * PER) @(negedge clk);
      rd_en = 1'b1;
      for (int j = 0; j < 3; j++) begin
        n = 0;
        do begin
          @(negedge clk);
          n++;
        end while (rd_valid !== 1'b1 && n < 40);
        cmp(rd_word, {r[7:0], r[7:0]}, "read word");
      end
      rd_en = 1'b0;
    end
    close_out();
  end
endmodule
